/* File: rtl/i2c_ten_bit_map.vh */
// Constants for the 10-bit addressing two-wire controller
`ifndef I2C_TEN_BIT_MAP_VH
`define I2C_TEN_BIT_MAP_VH
`define TEN_BIT_PREFIX      5'h1e
`define MODE_MASTER_SLAVE_7 2'h0
`define MODE_MASTER_SLAVE_10 2'h1
`define MODE_SLAVE_ONLY_10  2'h2
`define MODE_SLAVE_ONLY_7   2'h3
`define SCL_HALF_NS         2500
`define CLK_PERIOD_NS       20
`define SCL_HALF_CYCLES     ((`SCL_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_BYTE          8'h00
`endif

/* File: rtl/i2c_ten_bit_addressing.v */
// Two-wire controller: 10-bit master write/read addressing and 10-bit slave transmit
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ten_bit_map.vh"

// Behaviour
// R1 - Software opens master transfer with 11110, upper two bits, write bit zero.
// R2 - Start bit drives start condition then loads shift register from data buffer.
// R3 - Transmit interrupt raised after first bit of first address byte shifts out.
// R4 - After first address byte, shift register loads lower eight address bits.
// R5 - Another transmit interrupt after first bit of lower address byte.
// R6 - Address not acknowledged sets nack flag, ack-valid, clears ack status.
// R7 - Software answers nack by setting stop and clearing transmit interrupt enable.
// R8 - Stop after nack flushes pending data, sends stop, clears stop and nack flag.
// R9 - Read turnaround: repeated start, then 11110, upper bits, read bit one.
// R10 - Single-byte read: software sets not-acknowledge control bit.
// R11 - Remote acknowledges repeated first byte; otherwise same nack handling applies.
// R12 - Mode sets own slave address width only, not remote target width.
// R13 - Software programs mode, own address halves, enable with nack cleared.
// R14 - Slave acknowledges first byte with prefix, matching upper bits, write direction.
// R15 - Second byte match sets address-match flag, interrupt, read flag clear, acknowledge.
// R16 - Reading interrupt status clears the address-match flag.
// R17 - Repeated start, matching first byte, read: match flag, interrupt, read flag set.
// R18 - On read match software clears flag, loads data, sets transmit interrupt enable.
// R19 - Slave holds clock low until transmit data is available, then releases.
// R20 - Non-matching address gets no acknowledge; rest of transaction ignored.
module i2c_ten_bit_addressing
#(
  parameter HALF = `SCL_HALF_CYCLES
)
(
  // System
  input  wire       clk_i,
  input  wire       rst_n_i,
  // Configuration
  input  wire       controller_enable_i,
  input  wire [1:0] mode_i,
  input  wire [9:0] own_slave_address_i,
  input  wire       general_call_enable_i,
  // Control strobes and bits
  input  wire       start_set_i,
  input  wire       stop_set_i,
  input  wire       nak_ctl_i,
  input  wire       transmit_irq_enable_i,
  input  wire       data_write_i,
  input  wire [7:0] data_i,
  input  wire       status_read_i,
  // Status
  output reg        transmit_irq_o,
  output reg        nack_irq_flag_o,
  output reg        ack_valid_flag_o,
  output reg        ack_status_o,
  output reg        own_address_match_flag_o,
  output reg        read_dir_flag_o,
  output reg        stop_pending_o,
  output reg        busy_o,
  // Bus pins
  input  wire       scl_i,
  output reg        scl_o,
  output reg        scl_oe_o,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers
reg [1:0] scl_sync_ff;
reg [1:0] sda_sync_ff;
reg       scl_d_ff;
reg       sda_d_ff;
wire      scl_s = scl_sync_ff[1];
wire      sda_s = sda_sync_ff[1];
wire      scl_rise = scl_s & ~scl_d_ff;
wire      scl_fall = ~scl_s & scl_d_ff;
wire      bus_start = scl_s & scl_d_ff & ~sda_s & sda_d_ff;
wire      bus_stop = scl_s & scl_d_ff & sda_s & ~sda_d_ff;

always @(posedge clk_i or negedge rst_n_i)
begin
  if (!rst_n_i)
  begin
    scl_sync_ff <= 2'h3;
    sda_sync_ff <= 2'h3;
    scl_d_ff    <= 1'b1;
    sda_d_ff    <= 1'b1;
  end
  else
  begin
    scl_sync_ff <= {scl_sync_ff[0], scl_i};
    sda_sync_ff <= {sda_sync_ff[0], sda_i};
    scl_d_ff    <= scl_sync_ff[1];
    sda_d_ff    <= sda_sync_ff[1];
  end
end

////////////////////////////////////////////////////////////////////////
// Master engine: one phase per HALF cycles, four phases per bit
localparam M_IDLE  = 3'h0;
localparam M_START = 3'h1;
localparam M_BITS  = 3'h2;
localparam M_ACK   = 3'h3;
localparam M_STOP  = 3'h4;
localparam M_WAIT  = 3'h5;

reg [2:0]  m_state_ff;
reg [15:0] tick_ff;
reg [1:0]  phase_ff;
reg [3:0]  bit_ff;
reg [7:0]  shift_ff;
reg [7:0]  buf_ff;
reg        buf_full_ff;
reg        start_req_ff;
reg        addr_read_ff;
wire       tick = (tick_ff == HALF[15:0] - 16'h0001);
// Interrupt held back until the first bit of a byte has gone out
wire       first_bit_wait = (m_state_ff == M_START) | ((m_state_ff == M_BITS) & (bit_ff == 4'h0));

////////////////////////////////////////////////////////////////////////
// Slave engine
localparam S_IDLE  = 3'h0;
localparam S_ADDR1 = 3'h1;
localparam S_ADDR2 = 3'h2;
localparam S_ACK   = 3'h3;
localparam S_TX    = 3'h4;
localparam S_MACK  = 3'h5;
localparam S_IGN   = 3'h6;

reg [2:0] s_state_ff;
reg [7:0] s_shift_ff;
reg [3:0] s_cnt_ff;
reg       s_full_match_ff;
reg       s_ack_hold_ff;
reg       s_stretch_ff;

// R12 mode selects own width only
wire ten_mode = (mode_i == `MODE_MASTER_SLAVE_10) | (mode_i == `MODE_SLAVE_ONLY_10);

function first_byte_match;
  input [7:0] b;
  input [1:0] upper;
  begin
    first_byte_match = (b[7:3] == `TEN_BIT_PREFIX) & (b[2:1] == upper);
  end
endfunction

always @(posedge clk_i or negedge rst_n_i)
begin
  if (!rst_n_i)
  begin
    m_state_ff <= M_IDLE;
    tick_ff <= 16'h0000;
    phase_ff <= 2'h0;
    bit_ff <= 4'h0;
    shift_ff <= `RESET_BYTE;
    buf_ff <= `RESET_BYTE;
    buf_full_ff <= 1'b0;
    start_req_ff <= 1'b0;
    addr_read_ff <= 1'b0;
    transmit_irq_o <= 1'b0;
    nack_irq_flag_o <= 1'b0;
    ack_valid_flag_o <= 1'b0;
    ack_status_o <= 1'b0;
    stop_pending_o <= 1'b0;
    busy_o <= 1'b0;
    scl_o <= 1'b0;
    scl_oe_o <= 1'b0;
    sda_o <= 1'b0;
    sda_oe_o <= 1'b0;
    s_state_ff <= S_IDLE;
    s_shift_ff <= `RESET_BYTE;
    s_cnt_ff <= 4'h0;
    s_full_match_ff <= 1'b0;
    s_ack_hold_ff <= 1'b0;
    s_stretch_ff <= 1'b0;
    own_address_match_flag_o <= 1'b0;
    read_dir_flag_o <= 1'b0;
  end
  else
  begin
    tick_ff <= tick ? 16'h0000 : tick_ff + 16'h0001;
    if (data_write_i)
    begin
      buf_ff <= data_i;
      buf_full_ff <= 1'b1;
    end
    if (start_set_i)
      start_req_ff <= 1'b1;
    if (stop_set_i)
      stop_pending_o <= 1'b1;
    // R3 R5 irq after first bit
    transmit_irq_o <= transmit_irq_enable_i & ~buf_full_ff & ~data_write_i & busy_o & ~first_bit_wait;
    // R16 status read clears match flag
    if (status_read_i)
      own_address_match_flag_o <= 1'b0;
    busy_o <= (m_state_ff != M_IDLE);
    case (m_state_ff)
      M_IDLE:
      begin
        // R2 start request opens bus
        if (controller_enable_i & start_req_ff & buf_full_ff & scl_s & sda_s & tick)
        begin
          m_state_ff <= M_START;
          sda_o <= 1'b0;
          sda_oe_o <= 1'b1;
          phase_ff <= 2'h0;
        end
        else if (stop_pending_o & tick)
        begin
          stop_pending_o <= 1'b0;
          nack_irq_flag_o <= 1'b0;
        end
      end
      M_START:
        if (tick)
        begin
          scl_oe_o <= 1'b1;
          // R2 then R4 load shift register
          shift_ff <= buf_ff;
          addr_read_ff <= buf_ff[0];
          buf_full_ff <= data_write_i;
          start_req_ff <= 1'b0;
          bit_ff <= 4'h0;
          phase_ff <= 2'h0;
          m_state_ff <= M_BITS;
        end
      M_BITS:
        if (tick)
        begin
          phase_ff <= phase_ff + 2'h1;
          case (phase_ff)
            2'h0:
            begin
              sda_oe_o <= ~shift_ff[7];
              sda_o <= 1'b0;
            end
            2'h1: scl_oe_o <= 1'b0;
            2'h2: if (scl_s) phase_ff <= 2'h3; else phase_ff <= 2'h2;
            default:
            begin
              scl_oe_o <= 1'b1;
              shift_ff <= {shift_ff[6:0], 1'b0};
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == 4'h7)
              begin
                sda_oe_o <= 1'b0;
                m_state_ff <= M_ACK;
              end
            end
          endcase
        end
      M_ACK:
        if (tick)
        begin
          phase_ff <= phase_ff + 2'h1;
          case (phase_ff)
            2'h0: scl_oe_o <= 1'b0;
            2'h1: if (scl_s) phase_ff <= 2'h2; else phase_ff <= 2'h1;
            2'h2:
            begin
              ack_valid_flag_o <= 1'b1;
              ack_status_o <= ~sda_s;
              // R6 R11 no acknowledge
              if (sda_s)
                nack_irq_flag_o <= 1'b1;
            end
            default:
            begin
              scl_oe_o <= 1'b1;
              phase_ff <= 2'h0;
              if (nack_irq_flag_o)
                m_state_ff <= M_WAIT;
              // Clock held low one tick so the slave drops its acknowledge first
              else if (start_req_ff)
                m_state_ff <= M_WAIT;
              else if (buf_full_ff)
              begin
                // R4 lower address byte follows
                shift_ff <= buf_ff;
                buf_full_ff <= data_write_i;
                bit_ff <= 4'h0;
                m_state_ff <= M_BITS;
              end
              else
                m_state_ff <= M_WAIT;
            end
          endcase
        end
      M_WAIT:
        if (tick)
        begin
          if (stop_pending_o)
          begin
            // R8 flush, stop
            buf_full_ff <= 1'b0;
            sda_oe_o <= 1'b1;
            m_state_ff <= M_STOP;
            phase_ff <= 2'h0;
          end
          else if (start_req_ff)
          begin
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
            m_state_ff <= M_IDLE;
          end
          else if (buf_full_ff & ~nack_irq_flag_o)
          begin
            shift_ff <= buf_ff;
            buf_full_ff <= data_write_i;
            bit_ff <= 4'h0;
            m_state_ff <= M_BITS;
          end
        end
      M_STOP:
        if (tick)
        begin
          phase_ff <= phase_ff + 2'h1;
          if (phase_ff == 2'h0)
            scl_oe_o <= 1'b0;
          else if (phase_ff == 2'h1)
            sda_oe_o <= 1'b0;
          else
          begin
            // R8 clear stop and nack
            stop_pending_o <= 1'b0;
            nack_irq_flag_o <= 1'b0;
            m_state_ff <= M_IDLE;
          end
        end
      default: m_state_ff <= M_IDLE;
    endcase

    // Slave side; only while master idle
    if (bus_start & (m_state_ff == M_IDLE))
    begin
      s_state_ff <= controller_enable_i & ten_mode ? S_ADDR1 : S_IGN;
      s_cnt_ff <= 4'h0;
    end
    else if (bus_stop)
    begin
      s_state_ff <= S_IDLE;
      s_full_match_ff <= 1'b0;
      sda_oe_o <= (m_state_ff == M_IDLE) ? 1'b0 : sda_oe_o;
    end
    else
    case (s_state_ff)
      S_ADDR1, S_ADDR2:
      begin
        if (scl_rise)
        begin
          s_shift_ff <= {s_shift_ff[6:0], sda_s};
          s_cnt_ff <= s_cnt_ff + 4'h1;
        end
        if (scl_fall & (s_cnt_ff == 4'h8))
        begin
          s_cnt_ff <= 4'h0;
          if (s_state_ff == S_ADDR1)
          begin
            // R14 first byte write match
            if (first_byte_match(s_shift_ff, own_slave_address_i[9:8]) & ~s_shift_ff[0] & ~nak_ctl_i)
            begin
              s_ack_hold_ff <= 1'b0;
              s_state_ff <= S_ACK;
              sda_oe_o <= 1'b1;
              sda_o <= 1'b0;
            end
            // R17 repeated start read after full match
            else if (first_byte_match(s_shift_ff, own_slave_address_i[9:8]) & s_shift_ff[0] & s_full_match_ff)
            begin
              own_address_match_flag_o <= 1'b1;
              read_dir_flag_o <= 1'b1;
              s_ack_hold_ff <= 1'b1;
              s_state_ff <= S_ACK;
              sda_oe_o <= 1'b1;
              sda_o <= 1'b0;
            end
            else
              // R20 no acknowledge
              s_state_ff <= S_IGN;
          end
          // R15 second byte match
          else if (s_shift_ff == own_slave_address_i[7:0])
          begin
            own_address_match_flag_o <= 1'b1;
            read_dir_flag_o <= 1'b0;
            s_full_match_ff <= 1'b1;
            s_ack_hold_ff <= 1'b0;
            s_state_ff <= S_ACK;
            sda_oe_o <= 1'b1;
            sda_o <= 1'b0;
          end
          else
            s_state_ff <= S_IGN;
        end
      end
      S_ACK:
        if (scl_fall)
        begin
          sda_oe_o <= 1'b0;
          if (s_ack_hold_ff)
          begin
            // R19 stretch until data
            scl_oe_o <= 1'b1;
            s_stretch_ff <= 1'b1;
            s_state_ff <= S_TX;
          end
          else
            s_state_ff <= s_full_match_ff ? S_IGN : S_ADDR2;
        end
      S_TX:
      begin
        if (s_stretch_ff & buf_full_ff & transmit_irq_enable_i)
        begin
          s_stretch_ff <= 1'b0;
          s_shift_ff <= {buf_ff[6:0], 1'b0};
          buf_full_ff <= data_write_i;
          sda_oe_o <= ~buf_ff[7];
          sda_o <= 1'b0;
          scl_oe_o <= 1'b0;
          s_cnt_ff <= 4'h1;
        end
        else if (~s_stretch_ff & scl_fall)
        begin
          if (s_cnt_ff == 4'h8)
          begin
            sda_oe_o <= 1'b0;
            s_state_ff <= S_MACK;
          end
          else
          begin
            sda_oe_o <= ~s_shift_ff[7];
            s_shift_ff <= {s_shift_ff[6:0], 1'b0};
            s_cnt_ff <= s_cnt_ff + 4'h1;
          end
        end
      end
      S_MACK:
      begin
        if (scl_rise)
          s_ack_hold_ff <= ~sda_s;
        if (scl_fall)
        begin
          if (s_ack_hold_ff)
          begin
            scl_oe_o <= 1'b1;
            s_stretch_ff <= 1'b1;
            s_state_ff <= S_TX;
          end
          else
            s_state_ff <= S_IGN;
        end
      end
      default: s_state_ff <= s_state_ff;
    endcase
  end
end

endmodule // i2c_ten_bit_addressing
`default_nettype wire

/* File: verification/i2c_ten_bit_addressing_props.sv */
// Protocol checker for the 10-bit addressing two-wire controller
`timescale 1ns/1ps
`default_nettype none
module i2c_ten_bit_addressing_props
#(
  parameter HALF = 125
)
(
  // System
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic controller_enable_i,
  input wire logic transmit_irq_enable_i,
  input wire logic status_read_i,
  // Status
  input wire logic transmit_irq_o,
  input wire logic nack_irq_flag_o,
  input wire logic ack_valid_flag_o,
  input wire logic ack_status_o,
  input wire logic own_address_match_flag_o,
  input wire logic stop_pending_o,
  input wire logic busy_o,
  // Pins
  input wire logic scl_i,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o
);
  // Two ticks plus synchroniser slack
  localparam int LIM = 2 * HALF + 4;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_start;
    ($rose(sda_oe_o) && scl_i && !scl_oe_o) ##1 busy_o;
  endsequence
  sequence s_stop_done;
    $fell(stop_pending_o);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // start then clock
  a_start_clock: assert property (s_start |-> ##[1:LIM] scl_oe_o) else $error("no clock pull after start");
  a_txirq_busy: assert property (transmit_irq_o |-> $past(busy_o)) else $error("transmit irq while idle");
  a_nack_valid: assert property ($rose(nack_irq_flag_o) |-> ack_valid_flag_o && !ack_status_o) else $error("nack status wrong");
  a_txirq_enable: assert property (!transmit_irq_enable_i [*2] |-> !transmit_irq_o) else $error("irq while disabled");
  a_nack_held: assert property ($fell(nack_irq_flag_o) |-> s_stop_done) else $error("nack cleared without stop");
  a_stop_release: assert property (s_stop_done |-> ##[0:LIM] (!sda_oe_o && !scl_oe_o)) else $error("lines held after stop");
  a_match_clear: assert property (status_read_i && own_address_match_flag_o |=> !own_address_match_flag_o) else $error("match not cleared");
  a_match_enabled: assert property ($rose(own_address_match_flag_o) |-> controller_enable_i && !busy_o) else $error("bad match");
endmodule // i2c_ten_bit_addressing_props
`default_nettype wire

/* File: verification/i2c_far_end.sv */
// Behavioural far end: logging remote slave and stretch-aware remote master
`timescale 1ns/1ps
`default_nettype none
module i2c_far_end
(
  // Resolved bus lines
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Remote slave acknowledges its address bytes when high
  input  wire logic ack_on_i,
  // Pull-low requests
  output var  logic scl_pull_o,
  output var  logic sda_pull_o
);
  logic [7:0] got[$];
  logic [7:0] sh;
  logic       mst;
  logic       rw;
  int         cnt;
  int         nb;
  initial
  begin
    {scl_pull_o, sda_pull_o, mst, rw, sh} = 0;
    cnt = 0;
    nb = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Start condition restarts byte counting
  always @(negedge sda_i)
    if (scl_i === 1'b1)
    begin
      cnt = 0;
      nb = 0;
    end
  always @(posedge scl_i)
    if (!mst)
    begin
      if (cnt < 8) sh = {sh[6:0], sda_i};
      cnt++;
      if (cnt == 8) got.push_back(sh);
      if (cnt == 8 && nb == 0) rw = sh[0];
    end
  always @(negedge scl_i)
    if (!mst)
    begin
      if (cnt == 8) sda_pull_o = ack_on_i && (nb == 0 || (nb == 1 && !rw));
      if (cnt == 9)
      begin
        sda_pull_o = 0;
        cnt = 0;
        nb++;
      end
    end
  // Bounded wait, since a stuck stretch must not hang the run
  task automatic clk_bit(input logic b, output logic s);
    int w;
    w = 0;
    sda_pull_o = !b;
    #80 scl_pull_o = 0;
    while (scl_i !== 1'b1 && w < 4000)
    begin
      #20 w++;
    end
    #40 s = sda_i;
    #40 scl_pull_o = 1;
  endtask
  // Read uses b of all ones; the ninth bit is always a refusal on reads
  task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(b[i], s);
      r[i] = s;
    end
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic mstart;
    mst = 1;
    sda_pull_o = 0;
    #80 scl_pull_o = 0;
    #80 sda_pull_o = 1;
    #80 scl_pull_o = 1;
  endtask
  task automatic mstop;
    sda_pull_o = 1;
    #80 scl_pull_o = 0;
    #80 sda_pull_o = 0;
    #80 mst = 0;
  endtask
endmodule // i2c_far_end
`default_nettype wire

/* File: verification/i2c_ten_bit_addressing_test.sv */
// Self-checking bench for the 10-bit addressing two-wire controller
`timescale 1ns/1ps
`default_nettype none
module i2c_ten_bit_addressing_test;
  logic       clk_i, rst_n_i, controller_enable_i, general_call_enable_i, start_set_i, stop_set_i;
  logic       nak_ctl_i, transmit_irq_enable_i, data_write_i, status_read_i;
  logic [1:0] mode_i;
  logic [9:0] own_slave_address_i;
  logic [7:0] data_i, up_b, lo, db, rx;
  logic       transmit_irq_o, nack_irq_flag_o, ack_valid_flag_o, ack_status_o, own_address_match_flag_o;
  logic       read_dir_flag_o, stop_pending_o, busy_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
  logic       scl_pull, sda_pull, ack_on, a;
  wire        scl_i, sda_i;
  int         failures, checks, n;
  // Open-drain lines with pull-ups
  assign scl_i = !(scl_oe_o | scl_pull);
  assign sda_i = !(sda_oe_o | sda_pull);
  i2c_ten_bit_addressing #(.HALF(3)) dut
  (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .controller_enable_i(controller_enable_i), .mode_i(mode_i),
    .own_slave_address_i(own_slave_address_i), .general_call_enable_i(general_call_enable_i),
    .start_set_i(start_set_i), .stop_set_i(stop_set_i), .nak_ctl_i(nak_ctl_i),
    .transmit_irq_enable_i(transmit_irq_enable_i), .data_write_i(data_write_i), .data_i(data_i),
    .status_read_i(status_read_i), .transmit_irq_o(transmit_irq_o), .nack_irq_flag_o(nack_irq_flag_o),
    .ack_valid_flag_o(ack_valid_flag_o), .ack_status_o(ack_status_o),
    .own_address_match_flag_o(own_address_match_flag_o), .read_dir_flag_o(read_dir_flag_o),
    .stop_pending_o(stop_pending_o), .busy_o(busy_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o)
  );
  i2c_far_end part (.scl_i(scl_i), .sda_i(sda_i), .ack_on_i(ack_on), .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));
  initial
  begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task tick;
    @(posedge clk_i);
    #2;
  endtask
  task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    checks++;
    if (g !== e) begin failures++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end
  endtask
  task automatic wait_on(ref logic s, input logic v);
    int w;
    for (w = 0; s !== v && w < 20000; w++) tick();
    if (s !== v) begin failures++; $display("MISMATCH wait expected %h seen %h", v, s); end_sim(); end
  endtask
  task automatic strobe(ref logic s);
    tick();
    s = 1;
    tick();
    s = 0;
  endtask
  task wr_data(input logic [7:0] b);
    tick();
    data_i = b;
    data_write_i = 1;
    tick();
    data_write_i = 0;
  endtask
  task end_sim;
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    {rst_n_i, controller_enable_i, general_call_enable_i, start_set_i, stop_set_i, nak_ctl_i} = 0;
    {transmit_irq_enable_i, data_write_i, status_read_i, mode_i, own_slave_address_i, data_i, ack_on} = 0;
    failures = 0;
    checks = 0;
    void'($urandom(32'h9452));
    repeat (10) @(posedge clk_i);
    #2 rst_n_i = 1;
    repeat (3) tick();
    controller_enable_i = 1;
    // Remote slave refuses the first address byte
    up_b = {5'h1e, 2'($urandom()), 1'b0};
    lo = 8'($urandom());
    wr_data(up_b);
    transmit_irq_enable_i = 1;
    strobe(start_set_i);
    wait_on(transmit_irq_o, 1'b1);
    chk("busy", 1'b1, busy_o);
    chk("pin_level", 10'h0, {scl_o, sda_o});
    wr_data(lo);
    wait_on(nack_irq_flag_o, 1'b1);
    chk("ack_valid", 1'b1, ack_valid_flag_o);
    chk("ack_status", 1'b0, ack_status_o);
    chk("first_byte", up_b, part.got[0]);
    transmit_irq_enable_i = 0;
    strobe(stop_set_i);
    wait_on(nack_irq_flag_o, 1'b0);
    wait_on(busy_o, 1'b0);
    chk("stop_pending", 1'b0, stop_pending_o);
    chk("bytes_sent", 10'h1, 10'(part.got.size()));
    // Full address then read turnaround, any mode
    ack_on = 1;
    mode_i = 2'($urandom());
    part.got.delete();
    transmit_irq_enable_i = 1;
    wr_data(up_b);
    strobe(start_set_i);
    wait_on(transmit_irq_o, 1'b1);
    wr_data(lo);
    wait_on(transmit_irq_o, 1'b0);
    wait_on(transmit_irq_o, 1'b1);
    strobe(start_set_i);
    wr_data(up_b | 8'h01);
    nak_ctl_i = 1;
    for (n = 0; part.got.size() < 3 && n < 5000; n++) tick();
    if (n >= 5000) begin failures++; $display("MISMATCH read_bytes expected %h seen %h", 3, part.got.size()); end_sim(); end
    strobe(stop_set_i);
    wait_on(busy_o, 1'b0);
    chk("second_byte", lo, part.got[1]);
    chk("read_byte", up_b | 8'h01, part.got[2]);
    chk("read_nack", 1'b0, nack_irq_flag_o);
    nak_ctl_i = 0;
    transmit_irq_enable_i = 0;
    // Remote master addresses the slave side
    own_slave_address_i = 10'($urandom());
    mode_i = ($urandom() & 1) ? 2'h0 : 2'h3;
    repeat (3) tick();
    part.mstart();
    part.xfer({5'h1e, own_slave_address_i[9:8], 1'b0}, rx, a);
    chk("seven_ack", 1'b0, a);
    part.mstop();
    mode_i = ($urandom() & 1) ? 2'h1 : 2'h2;
    part.mstart();
    part.xfer({5'h1e, own_slave_address_i[9:8], 1'b0}, rx, a);
    chk("upper_ack", 1'b1, a);
    part.xfer(own_slave_address_i[7:0] ^ 8'h5a, rx, a);
    chk("wrong_ack", 1'b0, a);
    chk("wrong_match", 1'b0, own_address_match_flag_o);
    part.mstop();
    part.mstart();
    part.xfer({5'h1e, own_slave_address_i[9:8], 1'b0}, rx, a);
    part.xfer(own_slave_address_i[7:0], rx, a);
    chk("lower_ack", 1'b1, a);
    chk("match", 1'b1, own_address_match_flag_o);
    chk("read_dir", 1'b0, read_dir_flag_o);
    strobe(status_read_i);
    tick();
    chk("match_clear", 1'b0, own_address_match_flag_o);
    part.mstart();
    part.xfer({5'h1e, own_slave_address_i[9:8], 1'b1}, rx, a);
    chk("read_ack", 1'b1, a);
    chk("rematch", 1'b1, own_address_match_flag_o);
    chk("read_dir", 1'b1, read_dir_flag_o);
    db = 8'($urandom());
    fork
      part.xfer(8'hff, rx, a);
      begin
        repeat (40) tick();
        chk("stretch", 1'b1, scl_oe_o);
        strobe(status_read_i);
        wr_data(db);
        transmit_irq_enable_i = 1;
      end
    join
    chk("slave_data", db, rx);
    part.mstop();
    end_sim();
  end
endmodule // i2c_ten_bit_addressing_test
bind i2c_ten_bit_addressing i2c_ten_bit_addressing_props #(.HALF(HALF)) u_props
(
  .clk_i(clk_i), .rst_n_i(rst_n_i), .controller_enable_i(controller_enable_i),
  .transmit_irq_enable_i(transmit_irq_enable_i), .status_read_i(status_read_i), .transmit_irq_o(transmit_irq_o),
  .nack_irq_flag_o(nack_irq_flag_o), .ack_valid_flag_o(ack_valid_flag_o), .ack_status_o(ack_status_o),
  .own_address_match_flag_o(own_address_match_flag_o), .stop_pending_o(stop_pending_o), .busy_o(busy_o),
  .scl_i(scl_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o)
);
`default_nettype wire
